//--- inc/lane_cfg_pkg.sv
// Constants, field layouts and carrier types of the lane conditioning registers.
package lane_cfg_pkg;

  // ************************************************************
  // Register port geometry.
  // ************************************************************
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 8;

  // ************************************************************
  // Register offsets.
  // ************************************************************
  localparam logic [7:0] OFS_LANE1_OUT_IDLE_RATE = 8'h23;
  localparam logic [7:0] OFS_PORT_B_LANE1_IN_EQ = 8'h24;
  localparam logic [7:0] OFS_LANE1_OUT_SWING = 8'h25;
  localparam logic [7:0] OFS_LANE1_OUT_DEEMPHASIS = 8'h26;
  localparam logic [7:0] OFS_PORT_B_LANE1_IN_IDLE_THR = 8'h27;
  localparam logic [7:0] OFS_PORT_A_LANE0_OUT_IDLE_RATE = 8'h2B;

  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [7:0] RST_IDLE_RATE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h20;
  localparam logic [7:0] RST_SWING = 8'h03;
  localparam logic [7:0] RST_DEEMPHASIS = 8'h03;
  localparam logic [7:0] RST_IDLE_THR = 8'h00;

  // ************************************************************
  // Writable bit masks; reserved positions store and read zero.
  // ************************************************************
  localparam logic [7:0] MASK_IDLE_RATE = 8'h33;
  localparam logic [7:0] MASK_EQ = 8'h3F;
  localparam logic [7:0] MASK_SWING = 8'h7F;
  localparam logic [7:0] MASK_DEEMPHASIS = 8'hFF;
  localparam logic [7:0] MASK_IDLE_THR = 8'h0F;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int BIT_IDLE_AUTO = 5;
  localparam int BIT_IDLE_SELECT = 4;
  localparam int BIT_RATE_AUTO = 1;
  localparam int BIT_RATE_SELECT = 0;
  localparam int BIT_EQ_ENABLE = 5;
  localparam int GAIN_STAGE_MSB = 4;
  localparam int GAIN_STAGE_LSB = 3;
  localparam int BOOST_LEVEL_MSB = 2;
  localparam int BOOST_LEVEL_LSB = 0;
  localparam int BIT_DEEMPHASIS_TYPE = 7;
  localparam int DEEMPHASIS_LEVEL_MSB = 6;
  localparam int DEASSERT_THR_MSB = 3;
  localparam int DEASSERT_THR_LSB = 2;
  localparam int ASSERT_THR_MSB = 1;
  localparam int ASSERT_THR_LSB = 0;

  // ************************************************************
  // Code points of the swing, de-emphasis and equalizer fields.
  // ************************************************************
  localparam logic [6:0] SWING_CODE_600 = 7'h03;
  localparam logic [6:0] SWING_CODE_800 = 7'h07;
  localparam logic [6:0] SWING_CODE_1000 = 7'h0F;
  localparam logic [6:0] SWING_CODE_1200 = 7'h1F;
  localparam logic [6:0] SWING_CODE_RESERVED = 7'h3F;
  localparam logic [7:0] DEEMPH_CODE_0DB = 8'h01;
  localparam logic [7:0] DEEMPH_CODE_3P5DB = 8'hE8;
  localparam logic [7:0] DEEMPH_CODE_6DB = 8'h88;
  localparam logic [7:0] DEEMPH_CODE_9DB = 8'h90;
  localparam logic [7:0] DEEMPH_CODE_12DB = 8'hA0;
  localparam logic [5:0] EQ_CODE_BYPASS = 6'h20;

  // ************************************************************
  // Decoded settings and carrier types.
  // ************************************************************
  typedef enum logic [2:0] {
    SWING_600MV,
    SWING_800MV,
    SWING_1000MV,
    SWING_1200MV,
    SWING_RESERVED,
    SWING_UNLISTED
  } swing_level_type;

  typedef enum logic [2:0] {
    DEEMPH_0DB,
    DEEMPH_M3P5DB,
    DEEMPH_M6DB,
    DEEMPH_M9DB,
    DEEMPH_M12DB,
    DEEMPH_UNLISTED
  } deemphasis_level_type;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic write;
    logic read;
  } reg_request_type;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] rdata;
    logic rvalid;
  } reg_answer_type;

  typedef struct packed {
    logic mute;
    logic signal_detection_enable;
    logic rate_high;
  } channel_ctrl_type;

  typedef struct packed {
    logic enable;
    logic bypass;
    logic [1:0] gain_stage_field;
    logic [2:0] boost_level_field;
  } equalizer_ctrl_type;

  typedef struct packed {
    logic [1:0] deassert_code;
    logic [1:0] assert_code;
  } idle_threshold_type;

endpackage

//--- src/output_channel_ctrl.sv
// Idle and rate selection of one output channel.
`timescale 1ns/100ps

module output_channel_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Idle/rate register contents.
  input wire logic [7:0] idle_rate,
  // Detector inputs.
  input wire logic detector_idle,
  input wire logic detector_rate_high,
  // Resolved control.
  output lane_cfg_pkg::channel_ctrl_type ctrl
);

  logic idle_auto;
  logic idle_select;
  logic rate_auto;
  logic rate_select;

  assign idle_auto = idle_rate[lane_cfg_pkg::BIT_IDLE_AUTO];
  assign idle_select = idle_rate[lane_cfg_pkg::BIT_IDLE_SELECT];
  assign rate_auto = idle_rate[lane_cfg_pkg::BIT_RATE_AUTO];
  assign rate_select = idle_rate[lane_cfg_pkg::BIT_RATE_SELECT];

  // ************************************************************
  // Idle handling.
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl.mute <= 1'b0;
      ctrl.signal_detection_enable <= 1'b0;
    end else if (idle_auto) begin
      // The detector decides and the manual select bit is ignored.
      ctrl.mute <= detector_idle; // [R01]
      ctrl.signal_detection_enable <= 1'b1; // [R01]
    end else begin
      // Manual: 0 keeps the output on, 1 forces electrical idle.
      ctrl.mute <= idle_select; // [R02]
      ctrl.signal_detection_enable <= 1'b0; // [R02]
    end
  end

  // ************************************************************
  // Rate handling; high means the 5.0 to 6.4 Gbps range.
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl.rate_high <= 1'b0;
    end else if (rate_auto) begin
      ctrl.rate_high <= detector_rate_high; // [R03]
    end else begin
      ctrl.rate_high <= rate_select; // [R03] [R04]
    end
  end

endmodule

//--- src/lane_conditioning_config_regs.sv
// Configuration registers for lane signal conditioning and their decode.
`timescale 1ns/100ps

// Overview of operation
// R01: With idle-auto set, an output mutes from its own idle detector and the manual idle bit is ignored.
// R02: With idle-auto clear, idle-select 0 keeps the output on without detection and 1 forces electrical idle.
// R03: With rate-auto set the detected rate is used, otherwise the manual rate bit decides.
// R04: Manual rate 0 selects 2.5 to 3.2 Gbps and 1 selects 5.0 to 6.4 Gbps.
// R05: The equalizer field splits into enable bit 5, gain stage bits 4:3 and boost bits 2:0.
// R06: The equalizer offers 32 levels from 4 gain stages of 8 boost settings.
// R07: The equalizer field resets to 0x20, which bypasses the equalizer.
// R08: Swing codes 0x03, 0x07, 0x0F and 0x1F mean 600, 800, 1000 and 1200 mV, 0x03 by default.
// R09: The host never writes the reserved swing code 0x3F.
// R10: De-emphasis bit 7 picks compatibility or enhanced type and bits 6:0 the level.
// R11: De-emphasis codes 0x01, 0xE8, 0x88, 0x90 and 0xA0 mean 0, -3.5, -6, -9 and -12 dB.
// R12: The idle threshold field holds the de-assert code in bits 3:2 and the assert code in 1:0.
// R13: Threshold code 00 is the default 110/70 mV pair and higher codes raise both levels.
// R14: The host writes zero into reserved bit positions; the host model's raw writes keep reserved bits as given.
// R15: Every register reads back what was written and takes its default at reset; the registers store and read back zero in their reserved bit positions.
module lane_conditioning_config_regs (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET,
  // Register access port.
  input wire lane_cfg_pkg::reg_request_type REG_REQUEST,
  output lane_cfg_pkg::reg_answer_type REG_ANSWER,
  // Detector inputs of the two output channels.
  input wire logic LANE1_IDLE_DETECT,
  input wire logic LANE1_RATE_DETECT_HIGH,
  input wire logic PORT_A_LANE0_IDLE_DETECT,
  input wire logic PORT_A_LANE0_RATE_DETECT_HIGH,
  // Output channel idle and rate control.
  output lane_cfg_pkg::channel_ctrl_type LANE1_OUT_CTRL,
  output lane_cfg_pkg::channel_ctrl_type PORT_A_LANE0_OUT_CTRL,
  // Port B lane 1 input conditioning.
  output lane_cfg_pkg::equalizer_ctrl_type PORT_B_LANE1_EQ,
  output lane_cfg_pkg::idle_threshold_type PORT_B_LANE1_IDLE_THR,
  // Lane 1 output driver.
  output logic [6:0] LANE1_OUTPUT_SWING,
  output lane_cfg_pkg::swing_level_type LANE1_SWING_LEVEL,
  output logic LANE1_DEEMPHASIS_ENHANCED,
  output logic [6:0] LANE1_DEEMPHASIS_LEVEL,
  output lane_cfg_pkg::deemphasis_level_type LANE1_DEEMPHASIS_DB
);

  // ************************************************************
  // Register storage.
  // ************************************************************
  logic [7:0] lane1_out_idle_rate_ctrl;
  logic [7:0] port_b_lane1_in_equalizer;
  logic [7:0] lane1_out_swing;
  logic [7:0] lane1_out_deemphasis;
  logic [7:0] port_b_lane1_in_idle_threshold;
  logic [7:0] port_a_lane0_out_idle_rate_ctrl;
  logic [7:0] next_rdata;

  logic write_hit;
  logic [7:0] wdata;

  assign write_hit = REG_REQUEST.write;
  assign wdata = REG_REQUEST.wdata;

  // ************************************************************
  // Register writes; reserved bits are held at zero.
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lane1_out_idle_rate_ctrl <= lane_cfg_pkg::RST_IDLE_RATE; // [R15]
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_LANE1_OUT_IDLE_RATE) begin
      lane1_out_idle_rate_ctrl <= wdata & lane_cfg_pkg::MASK_IDLE_RATE; // [R15]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      port_b_lane1_in_equalizer <= lane_cfg_pkg::RST_EQ; // [R07] [R15]
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_PORT_B_LANE1_IN_EQ) begin
      port_b_lane1_in_equalizer <= wdata & lane_cfg_pkg::MASK_EQ; // [R15]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lane1_out_swing <= lane_cfg_pkg::RST_SWING; // [R08] [R15]
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_LANE1_OUT_SWING) begin
      lane1_out_swing <= wdata & lane_cfg_pkg::MASK_SWING; // [R15]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lane1_out_deemphasis <= lane_cfg_pkg::RST_DEEMPHASIS; // [R15]
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_LANE1_OUT_DEEMPHASIS) begin
      lane1_out_deemphasis <= wdata & lane_cfg_pkg::MASK_DEEMPHASIS; // [R15]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      port_b_lane1_in_idle_threshold <= lane_cfg_pkg::RST_IDLE_THR; // [R13]
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_PORT_B_LANE1_IN_IDLE_THR) begin
      port_b_lane1_in_idle_threshold <= wdata &
          lane_cfg_pkg::MASK_IDLE_THR; // [R15]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      port_a_lane0_out_idle_rate_ctrl <= lane_cfg_pkg::RST_IDLE_RATE;
    end else if (write_hit &&
        REG_REQUEST.addr == lane_cfg_pkg::OFS_PORT_A_LANE0_OUT_IDLE_RATE) begin
      port_a_lane0_out_idle_rate_ctrl <= wdata &
          lane_cfg_pkg::MASK_IDLE_RATE; // [R15]
    end
  end

  // ************************************************************
  // Register reads; unmapped offsets return zero.
  // ************************************************************
  always_comb begin
    unique case (REG_REQUEST.addr)
      lane_cfg_pkg::OFS_LANE1_OUT_IDLE_RATE: begin
        next_rdata = lane1_out_idle_rate_ctrl; // [R15]
      end
      lane_cfg_pkg::OFS_PORT_B_LANE1_IN_EQ: begin
        next_rdata = port_b_lane1_in_equalizer; // [R15]
      end
      lane_cfg_pkg::OFS_LANE1_OUT_SWING: begin
        next_rdata = lane1_out_swing; // [R15]
      end
      lane_cfg_pkg::OFS_LANE1_OUT_DEEMPHASIS: begin
        next_rdata = lane1_out_deemphasis; // [R15]
      end
      lane_cfg_pkg::OFS_PORT_B_LANE1_IN_IDLE_THR: begin
        next_rdata = port_b_lane1_in_idle_threshold; // [R15]
      end
      lane_cfg_pkg::OFS_PORT_A_LANE0_OUT_IDLE_RATE: begin
        next_rdata = port_a_lane0_out_idle_rate_ctrl; // [R15]
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REG_ANSWER.rdata <= 8'h00;
      REG_ANSWER.rvalid <= 1'b0;
    end else begin
      REG_ANSWER.rvalid <= REG_REQUEST.read;
      if (REG_REQUEST.read) begin
        REG_ANSWER.rdata <= next_rdata;
      end
    end
  end

  // ************************************************************
  // Output channel idle and rate control.
  // ************************************************************
  output_channel_ctrl lane1_channel (
    .clk(MCLK),
    .reset(RESET),
    .idle_rate(lane1_out_idle_rate_ctrl),
    .detector_idle(LANE1_IDLE_DETECT),
    .detector_rate_high(LANE1_RATE_DETECT_HIGH),
    .ctrl(LANE1_OUT_CTRL)
  );

  output_channel_ctrl port_a_lane0_channel (
    .clk(MCLK),
    .reset(RESET),
    .idle_rate(port_a_lane0_out_idle_rate_ctrl),
    .detector_idle(PORT_A_LANE0_IDLE_DETECT),
    .detector_rate_high(PORT_A_LANE0_RATE_DETECT_HIGH),
    .ctrl(PORT_A_LANE0_OUT_CTRL)
  );

  // ************************************************************
  // Receive equalizer decode.
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      // The default field 0x20 has its enable bit set, so enable follows it.
      PORT_B_LANE1_EQ.enable <= 1'b1; // [R05] [R07]
      PORT_B_LANE1_EQ.bypass <= 1'b1;
      PORT_B_LANE1_EQ.gain_stage_field <= 2'h0;
      PORT_B_LANE1_EQ.boost_level_field <= 3'h0;
    end else begin
      // Four gain stages by eight boost settings give 32 levels.
      PORT_B_LANE1_EQ.enable <=
          port_b_lane1_in_equalizer[lane_cfg_pkg::BIT_EQ_ENABLE]; // [R05]
      PORT_B_LANE1_EQ.bypass <= port_b_lane1_in_equalizer[5:0] ==
          lane_cfg_pkg::EQ_CODE_BYPASS; // [R07]
      PORT_B_LANE1_EQ.gain_stage_field <= port_b_lane1_in_equalizer[
          lane_cfg_pkg::GAIN_STAGE_MSB:lane_cfg_pkg::GAIN_STAGE_LSB]; // [R05] [R06]
      PORT_B_LANE1_EQ.boost_level_field <= port_b_lane1_in_equalizer[
          lane_cfg_pkg::BOOST_LEVEL_MSB:lane_cfg_pkg::BOOST_LEVEL_LSB]; // [R05] [R06]
    end
  end

  // ************************************************************
  // Idle threshold decode.
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PORT_B_LANE1_IDLE_THR.deassert_code <= 2'h0;
      PORT_B_LANE1_IDLE_THR.assert_code <= 2'h0;
    end else begin
      PORT_B_LANE1_IDLE_THR.deassert_code <= port_b_lane1_in_idle_threshold[
          lane_cfg_pkg::DEASSERT_THR_MSB:lane_cfg_pkg::DEASSERT_THR_LSB]; // [R12]
      PORT_B_LANE1_IDLE_THR.assert_code <= port_b_lane1_in_idle_threshold[
          lane_cfg_pkg::ASSERT_THR_MSB:lane_cfg_pkg::ASSERT_THR_LSB]; // [R12] [R13]
    end
  end

  // ************************************************************
  // Output swing decode.
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      LANE1_OUTPUT_SWING <= lane_cfg_pkg::SWING_CODE_600;
      LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_600MV; // [R08]
    end else begin
      LANE1_OUTPUT_SWING <= lane1_out_swing[6:0];
      unique case (lane1_out_swing[6:0])
        lane_cfg_pkg::SWING_CODE_600: begin
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_600MV; // [R08]
        end
        lane_cfg_pkg::SWING_CODE_800: begin
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_800MV; // [R08]
        end
        lane_cfg_pkg::SWING_CODE_1000: begin
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_1000MV; // [R08]
        end
        lane_cfg_pkg::SWING_CODE_1200: begin
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_1200MV; // [R08]
        end
        lane_cfg_pkg::SWING_CODE_RESERVED: begin
          // A host slip is flagged rather than silently driven.
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_RESERVED; // [R09]
        end
        default: begin
          LANE1_SWING_LEVEL <= lane_cfg_pkg::SWING_UNLISTED;
        end
      endcase
    end
  end

  // ************************************************************
  // De-emphasis decode.
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      LANE1_DEEMPHASIS_ENHANCED <= 1'b0;
      LANE1_DEEMPHASIS_LEVEL <= lane_cfg_pkg::RST_DEEMPHASIS[6:0];
    end else begin
      LANE1_DEEMPHASIS_ENHANCED <=
          lane1_out_deemphasis[lane_cfg_pkg::BIT_DEEMPHASIS_TYPE]; // [R10]
      LANE1_DEEMPHASIS_LEVEL <=
          lane1_out_deemphasis[lane_cfg_pkg::DEEMPHASIS_LEVEL_MSB:0]; // [R10]
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_UNLISTED;
    end else begin
      unique case (lane1_out_deemphasis)
        lane_cfg_pkg::DEEMPH_CODE_0DB: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_0DB; // [R11]
        end
        lane_cfg_pkg::DEEMPH_CODE_3P5DB: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_M3P5DB; // [R11]
        end
        lane_cfg_pkg::DEEMPH_CODE_6DB: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_M6DB; // [R11]
        end
        lane_cfg_pkg::DEEMPH_CODE_9DB: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_M9DB; // [R11]
        end
        lane_cfg_pkg::DEEMPH_CODE_12DB: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_M12DB; // [R11]
        end
        default: begin
          LANE1_DEEMPHASIS_DB <= lane_cfg_pkg::DEEMPH_UNLISTED;
        end
      endcase
    end
  end

endmodule

//--- verif/lane_cfg_checker.sv
// Checker of register access and decode timing of the lane config block.
`timescale 1ns/100ps

module lane_cfg_checker (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET,
  // Register port.
  input wire lane_cfg_pkg::reg_request_type REG_REQUEST,
  input wire lane_cfg_pkg::reg_answer_type REG_ANSWER,
  // Detectors.
  input wire logic LANE1_IDLE_DETECT,
  input wire logic LANE1_RATE_DETECT_HIGH,
  // Decoded outputs.
  input wire lane_cfg_pkg::channel_ctrl_type LANE1_OUT_CTRL,
  input wire lane_cfg_pkg::channel_ctrl_type PORT_A_LANE0_OUT_CTRL,
  input wire lane_cfg_pkg::equalizer_ctrl_type PORT_B_LANE1_EQ,
  input wire lane_cfg_pkg::idle_threshold_type PORT_B_LANE1_IDLE_THR,
  input wire logic [6:0] LANE1_OUTPUT_SWING,
  input wire lane_cfg_pkg::swing_level_type LANE1_SWING_LEVEL,
  input wire logic LANE1_DEEMPHASIS_ENHANCED,
  input wire logic [6:0] LANE1_DEEMPHASIS_LEVEL,
  input wire lane_cfg_pkg::deemphasis_level_type LANE1_DEEMPHASIS_DB
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic w23;
  logic w26;
  logic w27;
  logic w2b;
  logic [7:0] deemphasis_control;
  assign w23 = REG_REQUEST.write && REG_REQUEST.addr == 8'h23;
  assign w26 = REG_REQUEST.write && REG_REQUEST.addr == 8'h26;
  assign w27 = REG_REQUEST.write && REG_REQUEST.addr == 8'h27;
  assign w2b = REG_REQUEST.write && REG_REQUEST.addr == 8'h2B;
  assign deemphasis_control = {LANE1_DEEMPHASIS_ENHANCED, LANE1_DEEMPHASIS_LEVEL};
  AST_READ_ANSWER: assert property (
    REG_REQUEST.read |=> REG_ANSWER.rvalid)
    else $error("read not answered next cycle");
  AST_VALID_ONLY_ON_READ: assert property (
    !REG_REQUEST.read |=> !REG_ANSWER.rvalid)
    else $error("answer without read");
  AST_UNMAPPED_READ: assert property (
    REG_REQUEST.read && !(REG_REQUEST.addr inside {8'h23, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h2B}) |=> REG_ANSWER.rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IDLE_AUTO: assert property (
    LANE1_OUT_CTRL.signal_detection_enable |->
    LANE1_OUT_CTRL.mute == $past(LANE1_IDLE_DETECT))
    else $error("auto mute not from detector");
  AST_IDLE_MANUAL: assert property (
    (w23 && REG_REQUEST.wdata[5:4] == 2'h1) ##1 !w23 |=>
    LANE1_OUT_CTRL.mute && !LANE1_OUT_CTRL.signal_detection_enable)
    else $error("manual idle not muted");
  AST_RATE_AUTO: assert property (
    (w23 && REG_REQUEST.wdata[1]) ##1 !w23 |=>
    LANE1_OUT_CTRL.rate_high == $past(LANE1_RATE_DETECT_HIGH))
    else $error("auto rate not from detector");
  AST_RATE_MANUAL: assert property (
    (w2b && REG_REQUEST.wdata[1:0] == 2'h1) ##1 !w2b |=>
    PORT_A_LANE0_OUT_CTRL.rate_high)
    else $error("manual rate high not applied");
  AST_THR_FIELDS: assert property (
    w27 ##1 !w27 |=> {4'h0, PORT_B_LANE1_IDLE_THR} ==
    ($past(REG_REQUEST.wdata, 2) & 8'h0F))
    else $error("threshold fields wrong");
  AST_DEEMPH_FIELDS: assert property (
    w26 ##1 !w26 |=> deemphasis_control == $past(REG_REQUEST.wdata, 2))
    else $error("de-emphasis fields wrong");
  AST_EQ_BYPASS: assert property (
    PORT_B_LANE1_EQ.bypass == ({PORT_B_LANE1_EQ.enable,
    PORT_B_LANE1_EQ.gain_stage_field,
    PORT_B_LANE1_EQ.boost_level_field} == 6'h20))
    else $error("bypass flag wrong");
  AST_SWING_1200: assert property (
    LANE1_OUTPUT_SWING == 7'h1F |->
    LANE1_SWING_LEVEL == lane_cfg_pkg::SWING_1200MV)
    else $error("swing decode wrong");
  AST_DEEMPH_M6: assert property (
    deemphasis_control == 8'h88 |-> LANE1_DEEMPHASIS_DB == lane_cfg_pkg::DEEMPH_M6DB)
    else $error("de-emphasis decode wrong");
  COV_READ: cover property (REG_REQUEST.read ##1 REG_ANSWER.rvalid);
  COV_AUTO: cover property (LANE1_OUT_CTRL.signal_detection_enable);
  COV_DEEMPH: cover property (w26 ##1 !w26);
endmodule

bind lane_conditioning_config_regs lane_cfg_checker chk (
  .MCLK(MCLK), .RESET(RESET), .REG_REQUEST(REG_REQUEST),
  .REG_ANSWER(REG_ANSWER), .LANE1_IDLE_DETECT(LANE1_IDLE_DETECT),
  .LANE1_RATE_DETECT_HIGH(LANE1_RATE_DETECT_HIGH),
  .LANE1_OUT_CTRL(LANE1_OUT_CTRL),
  .PORT_A_LANE0_OUT_CTRL(PORT_A_LANE0_OUT_CTRL),
  .PORT_B_LANE1_EQ(PORT_B_LANE1_EQ),
  .PORT_B_LANE1_IDLE_THR(PORT_B_LANE1_IDLE_THR),
  .LANE1_OUTPUT_SWING(LANE1_OUTPUT_SWING),
  .LANE1_SWING_LEVEL(LANE1_SWING_LEVEL),
  .LANE1_DEEMPHASIS_ENHANCED(LANE1_DEEMPHASIS_ENHANCED),
  .LANE1_DEEMPHASIS_LEVEL(LANE1_DEEMPHASIS_LEVEL),
  .LANE1_DEEMPHASIS_DB(LANE1_DEEMPHASIS_DB));

//--- verif/mgmt_host_model.sv
// Management host model that programs the lane config registers.
`timescale 1ns/100ps

module mgmt_host_model (
  // Clock.
  input wire logic clk,
  // Register port.
  output lane_cfg_pkg::reg_request_type req,
  input wire lane_cfg_pkg::reg_answer_type ans
);
  initial req = '0;
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h23, 8'h2B: keep = lane_cfg_pkg::MASK_IDLE_RATE;
      8'h24: keep = lane_cfg_pkg::MASK_EQ;
      8'h25: keep = lane_cfg_pkg::MASK_SWING;
      8'h27: keep = lane_cfg_pkg::MASK_IDLE_THR;
      default: keep = 8'hFF;
    endcase
  endfunction
  // A raw write keeps reserved bits as given, to probe the masking.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
    if (a == 8'h25 && d[6:0] == 7'h3F) begin
      return;
    end
    @(posedge clk);
    #1;
    req = '{a, raw ? d : d & keep(a), 1'b1, 1'b0};
    @(posedge clk);
    #1;
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    req = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    #1;
    d = ans.rdata;
    v = ans.rvalid;
    req = '0;
  endtask
endmodule

//--- verif/tb_lane_conditioning_config_regs.sv
// Self-checking bench of the lane conditioning configuration registers.
`timescale 1ns/100ps

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_lane_conditioning_config_regs;
  logic mclk;
  logic reset;
  logic idle1;
  logic rate1;
  logic idle0;
  logic rate0;
  lane_cfg_pkg::reg_request_type req;
  lane_cfg_pkg::reg_answer_type ans;
  lane_cfg_pkg::channel_ctrl_type ctrl1;
  lane_cfg_pkg::channel_ctrl_type ctrl0;
  lane_cfg_pkg::equalizer_ctrl_type eq;
  lane_cfg_pkg::idle_threshold_type thr;
  logic [6:0] swing;
  logic [6:0] dlevel;
  lane_cfg_pkg::swing_level_type slevel;
  logic denh;
  lane_cfg_pkg::deemphasis_level_type ddb;
  int checks = 0;
  int miscompares = 0;
  logic [7:0] rdat;
  logic rv;
  logic [7:0] ofs [6] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B};
  logic [7:0] defs [6] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  logic [7:0] msk [6] = '{8'h33, 8'h3F, 8'h7F, 8'hFF, 8'h0F, 8'h33};

  mgmt_host_model host (.clk(mclk), .req(req), .ans(ans));

  lane_conditioning_config_regs dut (
    .MCLK(mclk), .RESET(reset), .REG_REQUEST(req), .REG_ANSWER(ans),
    .LANE1_IDLE_DETECT(idle1), .LANE1_RATE_DETECT_HIGH(rate1),
    .PORT_A_LANE0_IDLE_DETECT(idle0),
    .PORT_A_LANE0_RATE_DETECT_HIGH(rate0),
    .LANE1_OUT_CTRL(ctrl1), .PORT_A_LANE0_OUT_CTRL(ctrl0),
    .PORT_B_LANE1_EQ(eq), .PORT_B_LANE1_IDLE_THR(thr),
    .LANE1_OUTPUT_SWING(swing), .LANE1_SWING_LEVEL(slevel),
    .LANE1_DEEMPHASIS_ENHANCED(denh), .LANE1_DEEMPHASIS_LEVEL(dlevel),
    .LANE1_DEEMPHASIS_DB(ddb));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdat, rv);
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", e, rdat)
  endtask

  task automatic t_defaults();
    reset = 1'b1;
    step(10);
    reset = 1'b0;
    for (int i = 0; i < 6; i++) rdchk(ofs[i], defs[i]);
    `CHK("eq", 7'h60, eq)
    `CHK("thr", 4'h0, thr)
    `CHK("swing", lane_cfg_pkg::SWING_600MV, slevel)
    $display("test defaults done");
  endtask

  task automatic t_readback();
    for (int i = 0; i < 6; i++) begin
      host.wr(ofs[i], 8'hFF, 1'b1);
      rdchk(ofs[i], msk[i]);
    end
    `CHK("swing lvl", lane_cfg_pkg::SWING_UNLISTED, slevel)
    `CHK("dem db", lane_cfg_pkg::DEEMPH_UNLISTED, ddb)
    host.wr(8'h28, 8'h5A, 1'b1);
    rdchk(8'h28, 8'h00);
    $display("test readback done");
  endtask

  task automatic t_channel();
    logic [10:0] tab [7] = '{{8'h10, 3'h4}, {8'h00, 3'h0}, {8'h20, 3'h6},
      {8'h30, 3'h2}, {8'h02, 3'h1}, {8'h03, 3'h0}, {8'h01, 3'h1}};
    logic [1:0] det [7] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 7; i++) begin
        host.wr(l ? 8'h23 : 8'h2B, tab[i][10:3], 1'b0);
        {idle1, rate1} = det[i];
        {idle0, rate0} = det[i];
        step(1);
        `CHK("ctrl", tab[i][2:0], l ? ctrl1 : ctrl0)
      end
    end
    $display("test channel done");
  endtask

  task automatic t_swing();
    logic [6:0] c [4] = '{7'h03, 7'h07, 7'h0F, 7'h1F};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h25, {1'b0, c[i]}, 1'b0);
      step(1);
      `CHK("swing code", c[i], swing)
      `CHK("swing lvl", lane_cfg_pkg::swing_level_type'(i), slevel)
    end
    host.wr(8'h25, 8'h3F, 1'b0);
    rdchk(8'h25, 8'h1F);
    $display("test swing done");
  endtask

  task automatic t_deemph();
    logic [7:0] c [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h26, c[i], 1'b0);
      step(1);
      `CHK("dem", c[i], {denh, dlevel})
      `CHK("dem db", lane_cfg_pkg::deemphasis_level_type'(i), ddb)
    end
    $display("test deemphasis done");
  endtask

  task automatic t_eq_thr();
    logic [5:0] c [4] = '{6'h2A, 6'h3D, 6'h30, 6'h20};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h24, {2'h0, c[i]}, 1'b0);
      step(1);
      `CHK("eq", {c[i][5], c[i] == 6'h20, c[i][4:0]}, eq)
    end
    host.wr(8'h27, 8'h0B, 1'b0);
    step(1);
    `CHK("thr", 4'hB, thr)
    $display("test equalizer and threshold done");
  endtask

  initial begin
    reset = 1'b1;
    {idle1, rate1, idle0, rate0} = 4'h0;
    t_defaults();
    t_readback();
    t_defaults();
    t_channel();
    t_swing();
    t_deemph();
    t_eq_thr();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
endmodule
